// ---- rtl/cbtb_regs.vh ----
// constants shared by the conditional-prefix and table-branch decoder
`ifndef CBTB_REGS_VH
`define CBTB_REGS_VH

// ==========================================================
// instruction classes delivered by the earlier decode stage
`define CBTB_OP_OTHER      4'h0
`define CBTB_OP_PREFIX     4'h1
`define CBTB_OP_TB_BYTE    4'h2
`define CBTB_OP_TB_HALF    4'h3
`define CBTB_OP_BREAKPOINT_OP       4'h4
`define CBTB_OP_CPS_DIS    4'h5
`define CBTB_OP_CPS_ENA    4'h6
`define CBTB_OP_BARRIER    4'h7
`define CBTB_OP_BCOND      4'h8
`define CBTB_OP_CMP_BRANCH 4'h9
`define CBTB_OP_MEM        4'ha

// ==========================================================
// condition codes; the inverse of a code differs only in bit 0
`define CBTB_CC_EQ 4'h0
`define CBTB_CC_NE 4'h1
`define CBTB_CC_CS 4'h2
`define CBTB_CC_CC 4'h3
`define CBTB_CC_MI 4'h4
`define CBTB_CC_PL 4'h5
`define CBTB_CC_VS 4'h6
`define CBTB_CC_VC 4'h7
`define CBTB_CC_HI 4'h8
`define CBTB_CC_LS 4'h9
`define CBTB_CC_GE 4'ha
`define CBTB_CC_LT 4'hb
`define CBTB_CC_GT 4'hc
`define CBTB_CC_LE 4'hd
`define CBTB_CC_AL 4'he

// ==========================================================
// flag positions in the flags word, and block-state layout
`define CBTB_FLAG_N 3
`define CBTB_FLAG_Z 2
`define CBTB_FLAG_C 1
`define CBTB_FLAG_V 0
`define CBTB_BLOCK_MAX  3'h4
`define CBTB_BLOCK_NONE 3'h0
`define CBTB_STATE_W    11
`define CBTB_ZERO_STATE 11'h000
`define CBTB_OUTST_W    4
`define CBTB_TB_SHIFT   1
`define CBTB_OFS_SHIFT  1

`endif

// ---- rtl/cbtb_table_branch.v ----
// table branch engine: fetches the offset entry and forms the target
`timescale 1ns/1ps
`default_nettype none
`include "cbtb_regs.vh"

module cbtb_table_branch #(
  parameter ADDR_W = 32
) (
  input  wire              clock,
  input  wire              reset,
  input  wire              start,
  input  wire              halfForm,
  input  wire              baseIsPc,
  input  wire [ADDR_W-1:0] baseValue,
  input  wire [ADDR_W-1:0] indexValue,
  input  wire [ADDR_W-1:0] nextAddr,
  output wire              busy,
  output reg               done,
  output reg  [ADDR_W-1:0] target,
  output reg               rdValid,
  input  wire              rdReady,
  output reg  [ADDR_W-1:0] rdAddr,
  output reg               rdHalf,
  input  wire              rspValid,
  input  wire [15:0]       rspData
);

  localparam S_IDLE = 2'h0;
  localparam S_REQ  = 2'h1;
  localparam S_WAIT = 2'h2;

  reg [1:0]        state;
  reg [ADDR_W-1:0] fallAddr;
  wire [ADDR_W-1:0] tableBase;
  wire [ADDR_W-1:0] entryOfs;
  wire [15:0]       entry;

  // a program-counter base means the table starts right after the op
  assign tableBase = baseIsPc ? nextAddr : baseValue;
  assign entryOfs  = halfForm ? (indexValue << `CBTB_TB_SHIFT)
                              : indexValue;
  // byte form only looks at the low lane, entry is unsigned
  assign entry     = rdHalf ? rspData : {8'h00, rspData[7:0]};
  assign busy      = (state != S_IDLE);

  // ==========================================================
  // sequencing
  always @(posedge clock) begin
    if (reset) begin
      state    <= S_IDLE;
      done     <= 1'b0;
      target   <= {ADDR_W{1'b0}};
      rdValid  <= 1'b0;
      rdAddr   <= {ADDR_W{1'b0}};
      rdHalf   <= 1'b0;
      fallAddr <= {ADDR_W{1'b0}};
    end else begin
      done <= 1'b0;
      case (state)
        S_IDLE: begin
          if (start) begin
            rdAddr   <= tableBase + entryOfs;
            rdHalf   <= halfForm;
            rdValid  <= 1'b1;
            fallAddr <= nextAddr;
            state    <= S_REQ;
          end
        end
        S_REQ: begin
          if (rdReady) begin
            rdValid <= 1'b0;
            state   <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (rspValid) begin
            // forward only: offset is twice an unsigned entry
            target <= fallAddr
                    + {{(ADDR_W-17){1'b0}}, entry, 1'b0};
            done   <= 1'b1;
            state  <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // cbtb_table_branch

`default_nettype wire

// ---- rtl/cbtb_decoder.v ----
// conditional prefix, table branch, breakpoint, state change, barrier
`timescale 1ns/1ps
`default_nettype none
`include "cbtb_regs.vh"

// What this block does
// - conditionals need block; conditional branch gets range
// - these operations never write the flags
// - table entry at base plus scaled index
// - counter base means byte after instruction
// - target is next byte plus doubled entry
// - breakpoint enters debug, immediate ignored
// - breakpoint in block runs unconditionally
// - disable sets, enable clears selected masks
// - unprivileged state change changes nothing
// - earlier accesses complete before later ones
// - barrier leaves non-memory instructions alone
// - prefix conditions up to four instructions
// - block state survives exception and return
module cbtb_decoder #(
  parameter ADDR_W = 32
) (
  input  wire                     clock,
  input  wire                     reset,
  // decoded instruction stream
  input  wire                     instValid,
  output wire                     instReady,
  input  wire [3:0]               instOp,
  input  wire [3:0]               instCond,
  input  wire                     instHasCond,
  input  wire [2:0]               prefixLen,
  input  wire [2:0]               prefixElse,
  input  wire                     instWritesPc,
  input  wire [7:0]               instImm,
  input  wire                     cpsI,
  input  wire                     cpsF,
  input  wire                     privileged,
  input  wire                     baseIsPc,
  input  wire [ADDR_W-1:0]        baseValue,
  input  wire [ADDR_W-1:0]        indexValue,
  input  wire [ADDR_W-1:0]        nextAddr,
  input  wire [3:0]               flags,
  input  wire                     instSetsFlags,
  // exception entry and return
  input  wire                     excTake,
  input  wire                     excReturn,
  input  wire [`CBTB_STATE_W-1:0] excState,
  output wire [`CBTB_STATE_W-1:0] blockState,
  // results of the accepted instruction
  output reg                      issueValid,
  output reg                      issuePass,
  output reg                      flagsWrite,
  output reg                      wideBranch,
  output reg                      useFault,
  output reg                      debugEnter,
  output reg  [7:0]               debugImm,
  output reg                      interruptBlockBit,
  output reg                      allFaultBlockBit,
  output wire                     branchValid,
  output wire [ADDR_W-1:0]        branchTarget,
  // explicit access ordering
  input  wire                     accIssue,
  input  wire                     accDone,
  output wire                     accHold,
  // table read port
  output wire                     rdValid,
  input  wire                     rdReady,
  output wire [ADDR_W-1:0]        rdAddr,
  output wire                     rdHalf,
  input  wire                     rspValid,
  input  wire [15:0]              rspData
);

  // ==========================================================
  // condition evaluation
  function condPassF;
    input [3:0] cc;
    input [3:0] f;
    reg         n;
    reg         z;
    reg         c;
    reg         v;
    reg         r;
    begin
      n = f[`CBTB_FLAG_N];
      z = f[`CBTB_FLAG_Z];
      c = f[`CBTB_FLAG_C];
      v = f[`CBTB_FLAG_V];
      case (cc[3:1])
        3'h0:    r = z;
        3'h1:    r = c;
        3'h2:    r = n;
        3'h3:    r = v;
        3'h4:    r = c & ~z;
        3'h5:    r = (n == v);
        3'h6:    r = ~z & (n == v);
        default: r = 1'b1;
      endcase
      // the always code has no inverse form
      if (cc[3:1] != 3'h7 && cc[0])
        condPassF = ~r;
      else
        condPassF = r;
    end
  endfunction

  // ==========================================================
  // block state: base condition, else pattern, count left
  reg  [3:0] itBase;
  reg  [3:0] itPat;
  reg  [2:0] itLeft;
  wire       inBlock;
  wire [3:0] curCond;
  wire       lastInBlock;

  assign inBlock     = (itLeft != `CBTB_BLOCK_NONE);
  assign lastInBlock = (itLeft == 3'h1);
  // else slots use the inverse, which flips only bit 0
  assign curCond     = {itBase[3:1], itBase[0] ^ itPat[0]};
  assign blockState  = {itBase, itPat, itLeft};

  // ==========================================================
  // barrier: count explicit accesses still in flight
  reg  [`CBTB_OUTST_W-1:0] outstanding;
  reg                      barrierOpen;
  wire                     isMemOp;
  wire                     tbBusy;
  wire                     tbDone;
  wire                     accept;
  wire                     isTb;

  assign isMemOp = (instOp == `CBTB_OP_MEM);
  assign isTb    = (instOp == `CBTB_OP_TB_BYTE) ||
                   (instOp == `CBTB_OP_TB_HALF);
  // only later memory ops wait; other instructions flow past
  assign accHold   = barrierOpen;
  assign instReady = ~tbBusy & ~(barrierOpen & isMemOp);
  assign accept    = instValid & instReady;

  always @(posedge clock) begin
    if (reset) begin
      outstanding <= {`CBTB_OUTST_W{1'b0}};
      barrierOpen <= 1'b0;
    end else begin
      case ({accIssue, accDone})
        2'b10:   outstanding <= outstanding + 1'b1;
        2'b01:   outstanding <= outstanding - 1'b1;
        default: outstanding <= outstanding;
      endcase
      // held until every earlier access has reported completion
      if (accept && instOp == `CBTB_OP_BARRIER && !excTake)
        barrierOpen <= 1'b1;
      else if (outstanding == {`CBTB_OUTST_W{1'b0}} && !accIssue)
        barrierOpen <= 1'b0;
    end
  end

  // ==========================================================
  // pass decision for the instruction being accepted
  reg  passNow;
  reg  illegal;

  always @* begin
    passNow = 1'b1;
    if (instOp == `CBTB_OP_BREAKPOINT_OP)
      passNow = 1'b1;
    else if (inBlock)
      passNow = condPassF(curCond, flags);
    else if (instOp == `CBTB_OP_BCOND)
      passNow = condPassF(instCond, flags);
    illegal = 1'b0;
    // conditional suffix outside a block is only legal on a branch
    if (!inBlock && instHasCond && instOp != `CBTB_OP_BCOND)
      illegal = 1'b1;
    if (inBlock && (instOp == `CBTB_OP_PREFIX ||
                    instOp == `CBTB_OP_CMP_BRANCH ||
                    instOp == `CBTB_OP_CPS_DIS ||
                    instOp == `CBTB_OP_CPS_ENA))
      illegal = 1'b1;
    // counter writers and table branches must close the block
    if (inBlock && !lastInBlock && (instWritesPc || isTb))
      illegal = 1'b1;
  end

  // ==========================================================
  // block-state register
  always @(posedge clock) begin
    if (reset) begin
      itBase <= 4'h0;
      itPat  <= 4'h0;
      itLeft <= `CBTB_BLOCK_NONE;
    end else if (excReturn) begin
      // resume the interrupted block exactly where it stopped
      {itBase, itPat, itLeft} <= excState;
    end else if (excTake) begin
      itLeft <= `CBTB_BLOCK_NONE;
    end else if (accept) begin
      if (instOp == `CBTB_OP_PREFIX && !inBlock) begin
        itBase <= instCond;
        itPat  <= {prefixElse, 1'b0};
        if (prefixLen == 3'h0 || prefixLen > `CBTB_BLOCK_MAX)
          itLeft <= `CBTB_BLOCK_MAX;
        else
          itLeft <= prefixLen;
      end else if (inBlock) begin
        itPat  <= itPat >> 1;
        itLeft <= itLeft - 1'b1;
      end
    end
  end

  // ==========================================================
  // per-instruction results, masks and debug entry
  always @(posedge clock) begin
    if (reset) begin
      issueValid        <= 1'b0;
      issuePass         <= 1'b0;
      flagsWrite        <= 1'b0;
      wideBranch        <= 1'b0;
      useFault          <= 1'b0;
      debugEnter        <= 1'b0;
      debugImm          <= 8'h00;
      interruptBlockBit <= 1'b0;
      allFaultBlockBit  <= 1'b0;
    end else begin
      issueValid <= accept & ~excTake;
      debugEnter <= 1'b0;
      if (accept && !excTake) begin
        issuePass  <= passNow & ~illegal;
        useFault   <= illegal;
        wideBranch <= (instOp == `CBTB_OP_BCOND) & inBlock;
        case (instOp)
          `CBTB_OP_PREFIX, `CBTB_OP_TB_BYTE, `CBTB_OP_TB_HALF,
          `CBTB_OP_BREAKPOINT_OP, `CBTB_OP_CPS_DIS, `CBTB_OP_CPS_ENA,
          `CBTB_OP_BARRIER:
            flagsWrite <= 1'b0;
          default:
            flagsWrite <= instSetsFlags & passNow & ~illegal;
        endcase
        if (instOp == `CBTB_OP_BREAKPOINT_OP) begin
          debugEnter <= 1'b1;
          // kept only for the debugger, never acted on
          debugImm   <= instImm;
        end
        // unprivileged code leaves both masks untouched
        if (privileged && !illegal && !inBlock) begin
          if (instOp == `CBTB_OP_CPS_DIS) begin
            if (cpsI) interruptBlockBit <= 1'b1;
            if (cpsF) allFaultBlockBit  <= 1'b1;
          end else if (instOp == `CBTB_OP_CPS_ENA) begin
            if (cpsI) interruptBlockBit <= 1'b0;
            if (cpsF) allFaultBlockBit  <= 1'b0;
          end
        end
      end else begin
        issuePass  <= 1'b0;
        useFault   <= 1'b0;
        flagsWrite <= 1'b0;
        wideBranch <= 1'b0;
      end
    end
  end

  // ==========================================================
  // table branch engine; a failed condition skips the fetch
  wire tbStart;

  assign tbStart     = accept & ~excTake & isTb & passNow & ~illegal;
  assign branchValid = tbDone;

  cbtb_table_branch #(
    .ADDR_W     (ADDR_W)
  ) u_table (
    .clock      (clock),
    .reset      (reset),
    .start      (tbStart),
    .halfForm   (instOp == `CBTB_OP_TB_HALF),
    .baseIsPc   (baseIsPc),
    .baseValue  (baseValue),
    .indexValue (indexValue),
    .nextAddr   (nextAddr),
    .busy       (tbBusy),
    .done       (tbDone),
    .target     (branchTarget),
    .rdValid    (rdValid),
    .rdReady    (rdReady),
    .rdAddr     (rdAddr),
    .rdHalf     (rdHalf),
    .rspValid   (rspValid),
    .rspData    (rspData)
  );

endmodule // cbtb_decoder

`default_nettype wire

// ---- dv/cbtb_mem_model.sv ----
// memory-side model answering the decoder's table reads
`timescale 1ns/1ps
`default_nettype none
module cbtb_mem_model (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        slow,
  input  wire logic        rdValid,
  output var  logic        rdReady,
  input  wire logic [31:0] rdAddr,
  output var  logic        rspValid,
  output var  logic [15:0] rspData
);
  logic        pend;
  logic [1:0]  waitCnt;
  logic [31:0] addr;
  // data is the low half of the address so the bench can predict it;
  // between answers it toggles so stale data never looks valid
  always @(posedge clock) begin
    rdReady <= 1'b0;
    rspValid <= 1'b0;
    rspData <= ~rspData;
    if (reset) begin
      pend <= 1'b0;
      rspData <= 16'h5a5a;
    end else if (pend) begin
      waitCnt <= waitCnt - 2'h1;
      if (waitCnt == 2'h0) begin
        pend <= 1'b0;
        rspValid <= 1'b1;
        rspData <= addr[15:0];
      end
    end else if (rdValid && !rdReady) begin
      rdReady <= 1'b1;
      pend <= 1'b1;
      waitCnt <= slow ? 2'h3 : 2'h0;
      addr <= rdAddr;
    end
  end
endmodule // cbtb_mem_model
`default_nettype wire

// ---- dv/cbtb_decoder_asserts.sv ----
// concurrent checks on the decoder's ports
`timescale 1ns/1ps
`default_nettype none
`include "cbtb_regs.vh"
module cbtb_decoder_asserts #(
  parameter ADDR_W = 32
) (
  input wire logic                     clock,
  input wire logic                     reset,
  input wire logic                     instValid,
  input wire logic                     instReady,
  input wire logic [3:0]               instOp,
  input wire logic [7:0]               instImm,
  input wire logic                     cpsI,
  input wire logic                     cpsF,
  input wire logic                     privileged,
  input wire logic                     baseIsPc,
  input wire logic [ADDR_W-1:0]        baseValue,
  input wire logic [ADDR_W-1:0]        indexValue,
  input wire logic [ADDR_W-1:0]        nextAddr,
  input wire logic                     excTake,
  input wire logic                     excReturn,
  input wire logic [`CBTB_STATE_W-1:0] blockState,
  input wire logic                     issuePass,
  input wire logic                     flagsWrite,
  input wire logic                     debugEnter,
  input wire logic [7:0]               debugImm,
  input wire logic                     interruptBlockBit,
  input wire logic                     allFaultBlockBit,
  input wire logic                     branchValid,
  input wire logic [ADDR_W-1:0]        branchTarget,
  input wire logic                     accHold,
  input wire logic                     rdValid,
  input wire logic [ADDR_W-1:0]        rdAddr,
  input wire logic                     rspValid,
  input wire logic [15:0]              rspData
);
  wire acc = instValid && instReady && !excTake && !excReturn;
  wire idle = blockState[2:0] == `CBTB_BLOCK_NONE;
  reg  [ADDR_W-1:0] nextHeld;
  reg               halfHeld;
  wire [15:0]       entry = halfHeld ? rspData : {8'h00, rspData[7:0]};
  // the target is formed long after the accept, so keep its base here
  always @(posedge clock) begin
    if (acc && instOp[3:1] == 3'h1) begin
      nextHeld <= nextAddr;
      halfHeld <= instOp[0];
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence tb_req_s(op, pc);
    acc && idle && instOp == op && baseIsPc == pc ##1 rdValid;
  endsequence
  no_flags_a: assert property (
    acc && instOp inside {[`CBTB_OP_PREFIX:`CBTB_OP_BARRIER]}
    |=> !flagsWrite) else $error("flags written");
  breakpoint_op_debug_a: assert property (
    acc && instOp == `CBTB_OP_BREAKPOINT_OP |=> debugEnter && issuePass
    && debugImm == $past(instImm)) else $error("breakpoint missed");
  cps_set_a: assert property (
    acc && idle && privileged && instOp == `CBTB_OP_CPS_DIS
    |=> (!$past(cpsI) || interruptBlockBit)
    && (!$past(cpsF) || allFaultBlockBit)) else $error("mask not set");
  cps_keep_a: assert property (
    acc && !privileged
    && instOp inside {`CBTB_OP_CPS_DIS, `CBTB_OP_CPS_ENA}
    |=> $stable(interruptBlockBit) && $stable(allFaultBlockBit))
    else $error("unprivileged mask change");
  tb_addr_a: assert property (
    tb_req_s(`CBTB_OP_TB_HALF, 1'b0) |-> rdAddr ==
    $past(baseValue) + ($past(indexValue) << 1))
    else $error("table address wrong");
  tb_pcbase_a: assert property (
    tb_req_s(`CBTB_OP_TB_BYTE, 1'b1) |-> rdAddr ==
    $past(nextAddr) + $past(indexValue)) else $error("pc base wrong");
  tb_target_a: assert property (
    rspValid |=> branchValid
    && branchTarget == nextHeld + {$past(entry), 1'b0})
    else $error("branch target wrong");
  barrier_hold_a: assert property (
    acc && instOp == `CBTB_OP_BARRIER |=> accHold)
    else $error("barrier not held");
  mem_stall_a: assert property (
    accHold && instOp == `CBTB_OP_MEM |-> !instReady)
    else $error("access passed barrier");
endmodule // cbtb_decoder_asserts
bind cbtb_decoder cbtb_decoder_asserts #(.ADDR_W(ADDR_W)) u_chk (
  .clock(clock), .reset(reset), .instValid(instValid),
  .instReady(instReady), .instOp(instOp), .instImm(instImm),
  .cpsI(cpsI), .cpsF(cpsF), .privileged(privileged),
  .baseIsPc(baseIsPc), .baseValue(baseValue), .indexValue(indexValue),
  .nextAddr(nextAddr), .excTake(excTake), .excReturn(excReturn),
  .blockState(blockState), .issuePass(issuePass),
  .flagsWrite(flagsWrite), .debugEnter(debugEnter),
  .debugImm(debugImm), .interruptBlockBit(interruptBlockBit),
  .allFaultBlockBit(allFaultBlockBit), .branchValid(branchValid),
  .branchTarget(branchTarget), .accHold(accHold), .rdValid(rdValid),
  .rdAddr(rdAddr), .rspValid(rspValid), .rspData(rspData));
`default_nettype wire

// ---- dv/cbtb_decoder_bench.sv ----
// self-checking bench for the prefix and table branch decoder
`timescale 1ns/1ps
`default_nettype none
`include "cbtb_regs.vh"
module cbtb_decoder_bench;
  logic        clock, reset, instValid, instHasCond, instWritesPc, slow;
  logic        cpsI, cpsF, privileged, baseIsPc, instSetsFlags;
  logic        excTake, excReturn, accIssue, accDone;
  logic [3:0]  instOp, instCond, flags;
  logic [2:0]  prefixLen, prefixElse;
  logic [7:0]  instImm;
  logic [31:0] baseValue, indexValue, nextAddr;
  logic [10:0] excState;
  wire         instReady, issueValid, issuePass, flagsWrite, useFault;
  wire         debugEnter, intBit, faultBit, branchValid, accHold, wideBranch;
  wire         rdValid, rdReady, rdHalf, rspValid;
  wire  [7:0]  debugImm;
  wire  [31:0] branchTarget, rdAddr;
  wire  [15:0] rspData;
  wire  [10:0] blkState;
  int          n_errors, check_count, cycles;

  cbtb_decoder #(.ADDR_W(32)) u_dut (
    .clock(clock), .reset(reset), .instValid(instValid),
    .instReady(instReady), .instOp(instOp), .instCond(instCond),
    .instHasCond(instHasCond), .prefixLen(prefixLen),
    .prefixElse(prefixElse), .instWritesPc(instWritesPc),
    .instImm(instImm), .cpsI(cpsI), .cpsF(cpsF),
    .privileged(privileged), .baseIsPc(baseIsPc),
    .baseValue(baseValue), .indexValue(indexValue),
    .nextAddr(nextAddr), .flags(flags), .instSetsFlags(instSetsFlags),
    .excTake(excTake), .excReturn(excReturn), .excState(excState),
    .blockState(blkState), .issueValid(issueValid), .issuePass(issuePass),
    .flagsWrite(flagsWrite), .wideBranch(wideBranch), .useFault(useFault),
    .debugEnter(debugEnter), .debugImm(debugImm),
    .interruptBlockBit(intBit), .allFaultBlockBit(faultBit),
    .branchValid(branchValid), .branchTarget(branchTarget),
    .accIssue(accIssue), .accDone(accDone), .accHold(accHold),
    .rdValid(rdValid), .rdReady(rdReady), .rdAddr(rdAddr),
    .rdHalf(rdHalf), .rspValid(rspValid), .rspData(rspData));
  cbtb_mem_model u_mem (
    .clock(clock), .reset(reset), .slow(slow), .rdValid(rdValid),
    .rdReady(rdReady), .rdAddr(rdAddr), .rspValid(rspValid),
    .rspData(rspData));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // a run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      end_sim;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // called on a rising edge: offer one instruction, hold it until taken,
  // return at the following falling edge with the results up
  task automatic issue(input logic [3:0] op);
    logic r;
    instOp <= op;
    instValid <= 1'b1;
    do begin
      @(negedge clock);
      r = instReady;
      @(posedge clock);
    end while (!r);
    instValid <= 1'b0;
    @(negedge clock);
  endtask

  task automatic t_cps;
    privileged <= 1'b1;
    cpsI <= 1'b1;
    cpsF <= 1'b1;
    issue(`CBTB_OP_CPS_DIS);
    chk({issuePass, flagsWrite, intBit, faultBit}, 4'hb);
    @(posedge clock);
    privileged <= 1'b0;
    issue(`CBTB_OP_CPS_ENA);
    chk({intBit, faultBit}, 2'h3);
    @(posedge clock);
    privileged <= 1'b1;
    cpsI <= 1'b0;
    issue(`CBTB_OP_CPS_ENA);
    chk({intBit, faultBit}, 2'h2);
    @(posedge clock);
    instCond <= `CBTB_CC_EQ;
    prefixLen <= 3'h1;
    issue(`CBTB_OP_PREFIX);
    @(posedge clock);
    issue(`CBTB_OP_CPS_DIS);
    chk({useFault, intBit, faultBit}, 3'h6);
    $display("state change test done");
  endtask
  task automatic t_breakpoint_op;
    @(posedge clock);
    flags <= 4'h4;
    instCond <= `CBTB_CC_NE;
    prefixLen <= 3'h2;
    prefixElse <= 3'h1;
    issue(`CBTB_OP_PREFIX);
    @(posedge clock);
    instHasCond <= 1'b1;
    instImm <= 8'hab;
    issue(`CBTB_OP_BREAKPOINT_OP);
    chk({debugEnter, issuePass, debugImm}, 10'h3ab);
    @(posedge clock);
    instCond <= `CBTB_CC_EQ;
    issue(`CBTB_OP_OTHER);
    chk({issuePass, useFault, flagsWrite}, 3'h5);
    @(posedge clock);
    instHasCond <= 1'b0;
    $display("breakpoint test done");
  endtask
  task automatic t_tb(input logic half, input logic pc);
    logic [31:0] a, t;
    int          k;
    @(posedge clock);
    baseIsPc <= pc;
    slow <= half;
    baseValue <= 32'h0000_1000;
    indexValue <= 32'h0000_0005;
    nextAddr <= 32'h0000_2002;
    a = (pc ? 32'h2002 : 32'h1000) + (half ? 32'ha : 32'h5);
    t = 32'h2002 + (half ? {a[15:0], 1'b0} : {a[7:0], 1'b0});
    issue(half ? `CBTB_OP_TB_HALF : `CBTB_OP_TB_BYTE);
    chk({rdValid, rdHalf}, {1'b1, half});
    chk(rdAddr, a);
    for (k = 0; k < 20 && branchValid !== 1'b1; k++) @(negedge clock);
    chk(branchValid, 1'b1);
    chk(branchTarget, t);
    $display("table branch test done");
  endtask
  task automatic t_exc;
    @(posedge clock);
    instCond <= `CBTB_CC_EQ;
    prefixLen <= 3'h1;
    prefixElse <= 3'h0;
    issue(`CBTB_OP_PREFIX);
    @(posedge clock);
    excTake <= 1'b1;
    @(posedge clock);
    excTake <= 1'b0;
    // saved state: base equal, no else slots, one slot left
    excReturn <= 1'b1;
    excState <= 11'h001;
    @(negedge clock);
    chk(blkState, 11'h000);
    @(posedge clock);
    excReturn <= 1'b0;
    instHasCond <= 1'b1;
    instWritesPc <= 1'b1;
    issue(`CBTB_OP_BCOND);
    chk({issuePass, useFault, wideBranch}, 3'h5);
    @(posedge clock);
    instHasCond <= 1'b0;
    instWritesPc <= 1'b0;
    $display("exception test done");
  endtask
  task automatic t_bar;
    @(posedge clock);
    accIssue <= 1'b1;
    @(posedge clock);
    accIssue <= 1'b0;
    issue(`CBTB_OP_BARRIER);
    chk(accHold, 1'b1);
    @(posedge clock);
    instOp <= `CBTB_OP_OTHER;
    instValid <= 1'b1;
    // the non-memory op is taken at once; the memory op then waits
    @(posedge clock);
    instOp <= `CBTB_OP_MEM;
    @(negedge clock);
    chk({issueValid, instReady}, 2'h2);
    @(posedge clock);
    accDone <= 1'b1;
    @(posedge clock);
    accDone <= 1'b0;
    repeat (2) @(negedge clock);
    chk({accHold, instReady, issueValid}, 3'h2);
    @(posedge clock);
    instValid <= 1'b0;
    @(negedge clock);
    chk(issueValid, 1'b1);
    $display("barrier test done");
  endtask

  initial begin
    {instValid, instHasCond, instWritesPc, slow, cpsI, cpsF} = 6'h00;
    {privileged, baseIsPc, excTake, excReturn} = 4'h0;
    {accIssue, accDone, instSetsFlags, reset} = 4'h3;
    {instOp, instCond, flags, prefixLen, prefixElse} = 18'h00000;
    {instImm, excState} = 19'h00000;
    {baseValue, indexValue, nextAddr} = 96'h0;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    t_cps;
    t_breakpoint_op;
    t_exc;
    for (int i = 0; i < 4; i++) t_tb(i[0], i[1]);
    t_bar;
    end_sim;
  end
endmodule // cbtb_decoder_bench
`default_nettype wire
